// ===== include/scss_pkg.sv
// scss_pkg: constants and types for the system clock source selector.
// assumes a single 10 MHz system clock and word-aligned Avalon-MM addressing.
`default_nettype none
package scss_pkg;
  // ----------------------------------------------------------------
  // bus map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 4'h4;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CTRL_SRC_LSB = 0;
  localparam int CTRL_SRC_MSB = 1;
  localparam int CTRL_PLL_EN_BIT = 2;
  localparam int CTRL_TAP_LSB = 3;
  localparam int CTRL_TAP_MSB = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_ACT_LSB = 0;
  localparam int STAT_ACT_MSB = 1;
  localparam int STAT_BOOT_BIT = 2;
  localparam int STAT_BUSY_BIT = 3;
  localparam int STAT_GAIN_BIT = 4;

  // ----------------------------------------------------------------
  // nominal frequencies, for reference by software and bench
  // ----------------------------------------------------------------
  localparam int SLOW_RC_HZ = 20_000;
  localparam int FAST_RC_HZ = 12_000_000;
  localparam int XTAL_MIN_HZ = 4_000_000;
  localparam int XTAL_MAX_HZ = 16_000_000;
  localparam int PLL_MULT = 16;
  localparam int SYS_CLK_HZ = 10_000_000;

  typedef enum logic [1:0]
  {
    internal_slow_rc_mode = 2'h0,
    internal_fast_rc_mode = 2'h1,
    low_speed_crystal_mode = 2'h2,
    pll_source_mode = 2'h3
  } scss_src_type;

  // tap codes: system clock = crystal * 2**code
  typedef enum logic [2:0]
  {
    pll_times_one_tap = 3'h0,
    pll_times_two_tap = 3'h1,
    pll_times_four_tap = 3'h2,
    pll_times_eight_tap = 3'h3,
    pll_times_sixteen_tap = 3'h4
  } scss_tap_type;

  typedef enum logic [1:0]
  {
    SW_RUN = 2'h0,
    SW_WAIT_OLD = 2'h1,
    SW_WAIT_NEW = 2'h2
  } scss_sw_type;
endpackage
`default_nettype wire

// ===== rtl/scss_tap_div.sv
// scss_tap_div: divides the times-sixteen loop tick down to the selected tap.
// assumes vco_tick_in is a one-cycle enable at sixteen times the crystal rate.
`timescale 1ns/10ps
`default_nettype none
module scss_tap_div
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic enable_in,
  input wire scss_pkg::scss_tap_type tap_in,
  input wire logic vco_tick_in,
  output logic tap_tick_out
);
  import scss_pkg::*;

  logic [3:0] count_reg;
  logic [3:0] wrap_value;

  // wrap at 16/(2**tap)-1: sixteen tap passes every loop tick
  // unused tap codes fall back to times one rather than an odd ratio
  always_comb
  begin
    if (tap_in > pll_times_sixteen_tap)
      wrap_value = 4'(PLL_MULT - 1);
    else
      wrap_value = 4'((PLL_MULT >> tap_in) - 1);
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      count_reg <= 4'h0;
    else if (!enable_in)
      count_reg <= 4'h0;
    else if (vco_tick_in)
    begin
      if (count_reg >= wrap_value)
        count_reg <= 4'h0;
      else
        count_reg <= count_reg + 4'h1;
    end
  end

  assign tap_tick_out = enable_in && vco_tick_in && (count_reg >= wrap_value);
endmodule
`default_nettype wire

// ===== rtl/scss_top.sv
// scss_top: system clock source selector with boot-time default and
// glitch-free handover between sources.
// assumes oscillator ticks arrive as one-cycle enables synchronous to sys_clk_in.
//
// Behaviour
// - internal RC source offers slow (about 20 kHz) and fast (about 12 MHz).
// - with no configuration the fast RC source drives the system clock.
// - after boot completes, switch to the configured mode before the application runs.
// - crystal mode routes crystal pins as source, gain set for 4-16 MHz.
// - the loop may be enabled only with the crystal source, never with RC.
// - loop always multiplies by 16; system clock taken from tap x1..x16.
// - the times-four tap yields four times the crystal frequency.
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module scss_top
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic [scss_pkg::ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic slow_rc_tick_in,
  input wire logic fast_rc_tick_in,
  input wire logic crystal_in_pin_in,
  input wire logic vco_tick_in,
  input wire logic boot_done_in,
  output logic crystal_out_pin_out,
  output logic crystal_out_pin_oe_out,
  output logic osc_gain_out,
  output logic pll_enable_out,
  output logic sys_tick_out,
  output logic app_release_out
);
  import scss_pkg::*;

  // ----------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_reg;
  logic ack_reg;
  logic [31:0] readdata_reg;
  logic [31:0] status_word;
  logic req;

  assign req = avs_read_in || avs_write_in;
  // one wait cycle per access keeps read data registered
  assign avs_waitrequest_out = req && !ack_reg;
  assign avs_readdata_out = readdata_reg;

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ack_reg <= 1'b0;
    else
      ack_reg <= req && !ack_reg;
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      ctrl_reg <= CTRL_RESET;
    else if (avs_write_in && ack_reg && avs_address_in == CTRL_OFFSET)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (avs_byteenable_in[i])
          ctrl_reg[i*8 +: 8] <= avs_writedata_in[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      readdata_reg <= 32'h0000_0000;
    else if (avs_read_in && !ack_reg)
    begin
      unique case (avs_address_in)
        CTRL_OFFSET: readdata_reg <= ctrl_reg;
        STATUS_OFFSET: readdata_reg <= status_word;
        default: readdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // configured mode
  // ----------------------------------------------------------------
  scss_src_type cfg_src;
  scss_tap_type cfg_tap;
  logic cfg_pll;
  scss_src_type target_src;

  assign cfg_src = scss_src_type'(ctrl_reg[CTRL_SRC_MSB:CTRL_SRC_LSB]);
  assign cfg_tap = scss_tap_type'(ctrl_reg[CTRL_TAP_MSB:CTRL_TAP_LSB]);
  // a loop request with an RC source is ignored; source code 3 counts as crystal
  assign cfg_pll = ctrl_reg[CTRL_PLL_EN_BIT] && ctrl_reg[CTRL_SRC_MSB];

  always_comb
  begin
    if (cfg_pll)
      target_src = pll_source_mode;
    else if (cfg_src == pll_source_mode)
      target_src = low_speed_crystal_mode;
    else
      target_src = cfg_src;
  end

  // ----------------------------------------------------------------
  // boot sequencing
  // ----------------------------------------------------------------
  logic boot_seen_reg;
  scss_src_type active_src_reg;
  scss_src_type next_src_reg;
  scss_sw_type sw_state_reg;

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      boot_seen_reg <= 1'b0;
    else if (boot_done_in)
      boot_seen_reg <= 1'b1;
  end

  // application runs once boot is over and the configured source is live
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      app_release_out <= 1'b0;
    else if (boot_seen_reg && sw_state_reg == SW_RUN && active_src_reg == target_src)
      app_release_out <= 1'b1;
  end

  // ----------------------------------------------------------------
  // oscillator and loop
  // ----------------------------------------------------------------
  logic xtal_sample_reg;
  logic xtal_tick;
  logic pll_tick;
  logic xtal_needed;

  // crystal stays up while it or the loop is selected or about to be
  assign xtal_needed = boot_seen_reg &&
                       (target_src[1] || active_src_reg[1] || next_src_reg[1]);

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      xtal_sample_reg <= 1'b0;
    else
      xtal_sample_reg <= crystal_in_pin_in;
  end

  assign xtal_tick = crystal_in_pin_in && !xtal_sample_reg && xtal_needed;

  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      crystal_out_pin_out <= 1'b0;
      crystal_out_pin_oe_out <= 1'b0;
      osc_gain_out <= 1'b0;
      pll_enable_out <= 1'b0;
    end
    else
    begin
      // inverting drive of the crystal, gain for the 4-16 MHz range
      crystal_out_pin_out <= !crystal_in_pin_in;
      crystal_out_pin_oe_out <= xtal_needed;
      osc_gain_out <= xtal_needed;
      pll_enable_out <= boot_seen_reg && (cfg_pll || active_src_reg == pll_source_mode);
    end
  end

  scss_tap_div scss_tap_div_inst
  (
    .sys_clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .enable_in(pll_enable_out),
    .tap_in(cfg_tap),
    .vco_tick_in(vco_tick_in),
    .tap_tick_out(pll_tick)
  );

  function automatic logic src_tick(input scss_src_type sel, input logic slow_t,
                                    input logic fast_t, input logic xtal_t,
                                    input logic pll_t);
    unique case (sel)
      internal_slow_rc_mode: src_tick = slow_t;
      internal_fast_rc_mode: src_tick = fast_t;
      low_speed_crystal_mode: src_tick = xtal_t;
      pll_source_mode: src_tick = pll_t;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // glitch-free source switch
  // ----------------------------------------------------------------
  logic old_tick;
  logic new_tick;

  assign old_tick = src_tick(active_src_reg, slow_rc_tick_in, fast_rc_tick_in,
                             xtal_tick, pll_tick);
  assign new_tick = src_tick(next_src_reg, slow_rc_tick_in, fast_rc_tick_in,
                             xtal_tick, pll_tick);

  // old source finishes its period, output idles, new source starts a full one
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      sw_state_reg <= SW_RUN;
      active_src_reg <= internal_fast_rc_mode;
      next_src_reg <= internal_fast_rc_mode;
    end
    else
    begin
      unique case (sw_state_reg)
        SW_RUN:
          if (boot_seen_reg && target_src != active_src_reg)
          begin
            next_src_reg <= target_src;
            sw_state_reg <= SW_WAIT_OLD;
          end
        SW_WAIT_OLD:
          if (old_tick)
            sw_state_reg <= SW_WAIT_NEW;
        SW_WAIT_NEW:
          if (new_tick)
          begin
            active_src_reg <= next_src_reg;
            sw_state_reg <= SW_RUN;
          end
        default:
          sw_state_reg <= SW_RUN;
      endcase
    end
  end

  // the first new tick is swallowed so the new source's period is whole
  always_comb
  begin
    unique case (sw_state_reg)
      SW_RUN: sys_tick_out = old_tick;
      SW_WAIT_OLD: sys_tick_out = old_tick;
      default: sys_tick_out = 1'b0;
    endcase
  end

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_ACT_MSB:STAT_ACT_LSB] = active_src_reg;
    status_word[STAT_BOOT_BIT] = boot_seen_reg;
    status_word[STAT_BUSY_BIT] = (sw_state_reg != SW_RUN);
    status_word[STAT_GAIN_BIT] = osc_gain_out;
  end
endmodule
`default_nettype wire

// ===== testbench/scss_top_sva.sv
// scss_top_sva: port-level checks of the clock source selector.
// assumes bound to scss_top; oscillator ticks never arrive in adjacent cycles.
`timescale 1ns/10ps
`default_nettype none
module scss_top_sva
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic avs_waitrequest_out,
  input wire logic fast_rc_tick_in,
  input wire logic crystal_in_pin_in,
  input wire logic boot_done_in,
  input wire logic crystal_out_pin_out,
  input wire logic crystal_out_pin_oe_out,
  input wire logic osc_gain_out,
  input wire logic pll_enable_out,
  input wire logic sys_tick_out,
  input wire logic app_release_out
);
  logic seen_reg;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      seen_reg <= 1'b0;
    else if (boot_done_in)
      seen_reg <= 1'b1;
  end
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_pll_xtal; pll_enable_out |-> crystal_out_pin_oe_out; endproperty
  a_pll_xtal: assert property (p_pll_xtal) else $error("loop on without crystal");
  property p_gain; osc_gain_out == crystal_out_pin_oe_out; endproperty
  a_gain: assert property (p_gain) else $error("gain differs from drive");
  property p_xo; crystal_out_pin_oe_out && $past(resetn_in)
    |-> crystal_out_pin_out == !$past(crystal_in_pin_in); endproperty
  a_xo: assert property (p_xo) else $error("crystal drive not inverted");
  property p_wait; (avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out; endproperty
  a_wait: assert property (p_wait) else $error("bus wait too long");
  property p_rel_hold; app_release_out |=> app_release_out; endproperty
  a_rel_hold: assert property (p_rel_hold) else $error("release dropped");
  property p_rel_boot; $rose(app_release_out) |-> seen_reg; endproperty
  a_rel_boot: assert property (p_rel_boot) else $error("release before boot");
  property p_fast; !seen_reg |-> sys_tick_out == fast_rc_tick_in; endproperty
  a_fast: assert property (p_fast) else $error("boot clock not fast rc");
  // sources never tick twice in a row, so two adjacent ticks mean a glitch
  property p_glitch; sys_tick_out |=> !sys_tick_out; endproperty
  a_glitch: assert property (p_glitch) else $error("short clock period");
  c_rel: cover property ($rose(app_release_out));
  c_pll: cover property ($rose(pll_enable_out));
  c_read: cover property (avs_read_in && !avs_waitrequest_out);
endmodule
bind scss_top scss_top_sva scss_top_sva_inst (.sys_clk_in, .resetn_in, .avs_read_in,
  .avs_write_in, .avs_waitrequest_out, .fast_rc_tick_in, .crystal_in_pin_in, .boot_done_in,
  .crystal_out_pin_out, .crystal_out_pin_oe_out, .osc_gain_out, .pll_enable_out,
  .sys_tick_out, .app_release_out);
`default_nettype wire

// ===== testbench/scss_xtal_model.sv
// scss_xtal_model: external crystal plus loop tick source.
// assumes a crystal period of 32 system cycles; loop ticks at sixteen times that.
`timescale 1ns/10ps
`default_nettype none
module scss_xtal_model
(
  input wire logic sys_clk_in,
  input wire logic resetn_in,
  input wire logic drive_in,
  input wire logic pll_en_in,
  output logic xin_out,
  output logic vco_out
);
  localparam int HALF = 16;
  int cnt_reg;
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
      cnt_reg <= 0;
    else
      cnt_reg <= (cnt_reg + 1) % (2 * HALF);
  end
  // an undriven crystal does not ring; the pin then shows a changing pattern
  assign xin_out = drive_in ? (cnt_reg >= HALF) : cnt_reg[0];
  assign vco_out = pll_en_in && drive_in && !cnt_reg[0];
endmodule
`default_nettype wire

// ===== testbench/tb_scss_top.sv
// tb_scss_top: self-checking bench for the clock source selector.
// assumes the crystal model and the checker bound to scss_top.
`timescale 1ns/10ps
`default_nettype none
module tb_scss_top;
  import scss_pkg::*;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [ADDR_W-1:0] avs_address_in = '0;
  logic avs_read_in = 1'b0;
  logic avs_write_in = 1'b0;
  logic [31:0] avs_writedata_in = '0;
  logic [3:0] avs_byteenable_in = 4'hF;
  logic slow_rc_tick_in = 1'b0;
  logic fast_rc_tick_in = 1'b0;
  logic boot_done_in = 1'b0;
  logic crystal_in_pin_in, vco_tick_in, avs_waitrequest_out, crystal_out_pin_out;
  logic crystal_out_pin_oe_out, osc_gain_out, pll_enable_out, sys_tick_out;
  logic app_release_out;
  logic [31:0] avs_readdata_out, rd_val, meas;
  logic meas_v = 1'b0;
  logic [32:0] exp_q[$];
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  int nsys = 0;
  scss_top scss_top_inst (.sys_clk_in, .resetn_in, .avs_address_in, .avs_read_in,
    .avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
    .avs_waitrequest_out, .slow_rc_tick_in, .fast_rc_tick_in, .crystal_in_pin_in,
    .vco_tick_in, .boot_done_in, .crystal_out_pin_out, .crystal_out_pin_oe_out,
    .osc_gain_out, .pll_enable_out, .sys_tick_out, .app_release_out);
  scss_xtal_model scss_xtal_model_inst (.sys_clk_in, .resetn_in,
    .drive_in(crystal_out_pin_oe_out), .pll_en_in(pll_enable_out),
    .xin_out(crystal_in_pin_in), .vco_out(vco_tick_in));
  // ----------------------------------------------------------------
  // clock, rc ticks and monitor
  // ----------------------------------------------------------------
  always #50 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in)
  begin
    cyc <= cyc + 1;
    slow_rc_tick_in <= (cyc % 50 == 49);
    fast_rc_tick_in <= (cyc % 6 == 5);
  end
  // ticks are counted mid-cycle so the count never races the stimulus edge
  always @(negedge sys_clk_in)
  begin
    if (sys_tick_out === 1'b1)
      nsys++;
  end
  // read data is taken at the rising edge where waitrequest is sampled low
  always @(posedge sys_clk_in)
  begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 || meas_v === 1'b1)
      cmp(meas_v ? meas : avs_readdata_out);
  end
  task automatic cmp(input logic [31:0] got);
    logic [32:0] e;
    e = exp_q.pop_front();
    if (e[32] === 1'b1)
    begin
      checks++;
      if (got !== e[31:0])
      begin
        n_mismatch++;
        $display("[ERR] t=%0t exp=%h got=%h", $time, e[31:0], got);
      end
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic stall;
    n_mismatch++;
    give_verdict();
  endtask
  // ----------------------------------------------------------------
  // bus, settle and tick count
  // ----------------------------------------------------------------
  // a read notes its expected value, bit 32 says whether it is compared
  task automatic bus(input logic w, input logic [3:0] a, input logic [32:0] d);
    int i;
    @(posedge sys_clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d[31:0];
    avs_write_in <= w;
    avs_read_in <= !w;
    if (!w)
      exp_q.push_back(d);
    i = 0;
    do
    begin
      @(posedge sys_clk_in);
      i++;
    end
    while (avs_waitrequest_out !== 1'b0 && i < 9);
    if (!w)
      rd_val = avs_readdata_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    if (i >= 9)
      stall();
  endtask
  task automatic settle(input logic [31:0] st);
    int i;
    for (i = 0; i < 40; i++)
    begin
      bus(1'b0, STATUS_OFFSET, {1'b0, 32'h0});
      if (rd_val === st)
        break;
    end
    if (i == 40)
      stall();
    else
      bus(1'b0, STATUS_OFFSET, {1'b1, st});
  endtask
  // hands a sampled value to the monitor; never call twice in a row
  task automatic note(input logic [31:0] v, input logic [31:0] e);
    meas <= v;
    meas_v <= 1'b1;
    exp_q.push_back({1'b1, e});
    @(posedge sys_clk_in);
    meas_v <= 1'b0;
  endtask
  task automatic count(input int n, input logic [31:0] e);
    int s;
    s = nsys;
    repeat (n) @(posedge sys_clk_in);
    note(32'(nsys - s), e);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [3:0] a;
    void'($urandom(32'h2e4f934a));
    repeat (12) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    bus(1'b0, CTRL_OFFSET, {1'b1, CTRL_RESET});
    bus(1'b0, STATUS_OFFSET, {1'b1, 32'h0000_0001});
    count(60, 32'h0000_000A);
    bus(1'b1, CTRL_OFFSET, {1'b0, 32'h0000_0000});
    count(60, 32'h0000_000A);
    a = {1'b1, 1'($urandom), 2'b00};
    bus(1'b1, a, {1'b0, $urandom});
    bus(1'b0, a, {1'b1, 32'h0000_0000});
    bus(1'b0, CTRL_OFFSET, {1'b1, 32'h0000_0000});
    note({29'h0, pll_enable_out, osc_gain_out, app_release_out}, 32'h0000_0000);
    boot_done_in <= 1'b1;
    settle(32'h0000_0004);
    note({29'h0, pll_enable_out, osc_gain_out, app_release_out}, 32'h0000_0001);
    count(500, 32'h0000_000A);
    bus(1'b1, CTRL_OFFSET, {1'b0, 32'h0000_0005});
    settle(32'h0000_0005);
    note({29'h0, pll_enable_out, osc_gain_out, app_release_out}, 32'h0000_0001);
    bus(1'b1, CTRL_OFFSET, {1'b0, 32'h0000_0002});
    settle(32'h0000_0016);
    note({29'h0, pll_enable_out, osc_gain_out, app_release_out}, 32'h0000_0003);
    count(320, 32'h0000_000A);
    for (int t = 0; t < 5; t++)
    begin
      bus(1'b1, CTRL_OFFSET, {1'b0, 32'(6 + 8 * t)});
      settle(32'h0000_0017);
      note({29'h0, pll_enable_out, osc_gain_out, app_release_out}, 32'h0000_0007);
      count(320, 32'(32'h0000_000A << t));
    end
    give_verdict();
  end
endmodule
`default_nettype wire
